// [hw/energy_pulse_cond.sv]
// How it works
// - accumulation field 00 with active power selected: phase powers summed with sign.
// - accumulation field 11: negative active powers negated for pulse path only.
// - reactive accumulation field applies only when converter selects type 001 or 100.
// - reactive field 00: reactive powers summed with their signs.
// - reactive field 10: reactive power negated where that phase's active power is negative.
// - sum sign checked each time the 55-bit accumulator crosses its threshold.
// - reverse-sum flags 18, 13, 9 set on the next falling pulse edge after a change.
// - sum-sign bits 8, 7, 3 updated with those flags; 1 means negative.
// - masked reverse-sum flags pull the first interrupt line low.
// - writing 1 to a set status flag clears it; the line goes high once no masked flag is left set.
// - phase in power no-load when both magnitudes are at or below thresholds.
// - negative active or reactive threshold disables the power no-load detector.
// - thresholds are 24-bit signed, read with top four bits zero, extended to 28.
// - power no-load change sets status bit 0 and updates phase bits 2..0.
// - masked power no-load flag pulls the second interrupt line low.
// - phase in apparent no-load when apparent magnitude is at or below threshold.
// - negative apparent threshold disables the apparent no-load detector.
// - apparent no-load change sets status bit 2 and updates phase bits 8..6.
// - masked apparent no-load flag pulls the second interrupt line low.
// - first stage adds powers shifted left seven at 1 MHz, subtracts threshold on a positive pulse, adds it on a negative one.
// - status flags set regardless of masks; masks only gate the lines.
`timescale 1ns/100ps
`default_nettype none
module energy_pulse_cond (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_valid,
  input wire logic signed [27:0] active_power_a,
  input wire logic signed [27:0] active_power_b,
  input wire logic signed [27:0] active_power_c,
  input wire logic signed [27:0] reactive_power_a,
  input wire logic signed [27:0] reactive_power_b,
  input wire logic signed [27:0] reactive_power_c,
  input wire logic signed [27:0] apparent_power_a,
  input wire logic signed [27:0] apparent_power_b,
  input wire logic signed [27:0] apparent_power_c,
  input wire logic [8:0] pulse_power_type_select,
  input wire logic [8:0] phase_term_select,
  input wire logic [47:0] active_energy_threshold,
  input wire logic [47:0] reactive_energy_threshold,
  input wire logic [47:0] apparent_energy_threshold,
  input wire logic [2:0] pulse_output_fall,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic [2:0] stage1_pulse,
  output logic [2:0] power_noload_phase_state,
  output logic [2:0] apparent_noload_phase_state,
  output logic first_interrupt_line_n,
  output logic second_interrupt_line_n
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [27:0] magnitude(input logic signed [27:0] x);
    magnitude = x[27] ? 28'(-x) : 28'(x);
  endfunction : magnitude

  function automatic logic signed [27:0] sext28(input logic [23:0] t);
    sext28 = {{4{t[23]}}, t};
  endfunction : sext28

  // conditioned contribution of one phase to one converter
  function automatic logic signed [29:0] cond_power(
    input logic [2:0] sel,
    input logic [1:0] amode,
    input logic [1:0] rmode,
    input logic signed [27:0] act,
    input logic signed [27:0] rea,
    input logic signed [27:0] app,
    input logic nl_pq,
    input logic nl_app
  );
    logic signed [29:0] a;
    logic signed [29:0] r;
    a = 30'(act);
    r = 30'(rea);
    cond_power = 30'sh0;
    if (sel == energy_cond_pkg::SEL_ACTIVE) begin
      if (!nl_pq) begin
        if (amode == energy_cond_pkg::ACC_ABSOLUTE && act < 0) begin
          cond_power = -a;
        end else begin
          cond_power = a;
        end
      end
    end else if (sel == energy_cond_pkg::SEL_REACTIVE || sel == energy_cond_pkg::SEL_REACTIVE_FUND) begin
      if (!nl_pq) begin
        if (rmode == energy_cond_pkg::ACC_SIGN_ADJUSTED && act < 0) begin
          cond_power = -r;
        end else begin
          cond_power = r;
        end
      end
    end else if (sel == energy_cond_pkg::SEL_APPARENT) begin
      if (!nl_app) begin
        cond_power = 30'(app);
      end
    end
  endfunction : cond_power

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] accumulation_mode;
  logic [31:0] active_status;
  logic [15:0] phase_sign;
  logic [31:0] active_mask;
  logic [23:0] active_noload_threshold;
  logic [23:0] reactive_noload_threshold;
  logic [31:0] secondary_status;
  logic [15:0] phase_noload_state;
  logic [31:0] secondary_mask;
  logic [4:0] tick_cnt;
  logic signed [54:0] acc [3];
  logic [2:0] last_sign;
  logic [2:0] sign_pending;

  logic [7:0] next_accumulation_mode;
  logic [31:0] next_active_status;
  logic [15:0] next_phase_sign;
  logic [31:0] next_active_mask;
  logic [23:0] next_active_noload_threshold;
  logic [23:0] next_reactive_noload_threshold;
  logic [31:0] next_secondary_status;
  logic [15:0] next_phase_noload_state;
  logic [31:0] next_secondary_mask;
  logic [23:0] next_apparent_noload_threshold;
  logic [23:0] apparent_noload_threshold;
  logic [31:0] next_reg_rdata;
  logic next_first_irq_n;
  logic next_second_irq_n;
  logic [4:0] next_tick_cnt;
  logic signed [54:0] next_acc [3];
  logic [2:0] next_last_sign;
  logic [2:0] next_sign_pending;
  logic [2:0] next_stage1_pulse;

  logic signed [27:0] p_act [3];
  logic signed [27:0] p_rea [3];
  logic signed [27:0] p_app [3];
  logic tick;

  assign p_act = '{active_power_a, active_power_b, active_power_c};
  assign p_rea = '{reactive_power_a, reactive_power_b, reactive_power_c};
  assign p_app = '{apparent_power_a, apparent_power_b, apparent_power_c};
  assign tick = (tick_cnt == 5'h00);
  assign power_noload_phase_state = phase_noload_state[2:0];
  assign apparent_noload_phase_state = phase_noload_state[8:6];

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic signed [27:0] thr_a;
    logic signed [27:0] thr_r;
    logic signed [27:0] thr_v;
    logic pq_en;
    logic app_en;
    logic [2:0] nl_pq;
    logic [2:0] nl_app;
    logic [31:0] clr0;
    logic [31:0] clr1;
    logic [31:0] set0;
    logic [31:0] set1;
    logic [2:0] sel;
    logic [47:0] ethr;
    logic signed [29:0] sum;
    logic signed [55:0] accx;
    logic signed [55:0] thr7;
    logic [1:0] amode;
    logic [1:0] rmode;
    sel = 3'h0;
    ethr = 48'h0;
    sum = 30'sh0;
    accx = 56'sh0;
    thr7 = 56'sh0;
    thr_a = sext28(active_noload_threshold);
    thr_r = sext28(reactive_noload_threshold);
    thr_v = sext28(apparent_noload_threshold);
    // either negative threshold turns the power detector off
    pq_en = !thr_a[27] && !thr_r[27];
    app_en = !thr_v[27];
    amode = accumulation_mode[energy_cond_pkg::ACTIVE_ACC_LSB +: 2];
    rmode = accumulation_mode[energy_cond_pkg::REACTIVE_ACC_LSB +: 2];
    nl_pq = phase_noload_state[2:0];
    nl_app = phase_noload_state[8:6];

    next_accumulation_mode = accumulation_mode;
    next_active_mask = active_mask;
    next_secondary_mask = secondary_mask;
    next_active_noload_threshold = active_noload_threshold;
    next_reactive_noload_threshold = reactive_noload_threshold;
    next_apparent_noload_threshold = apparent_noload_threshold;
    next_phase_sign = phase_sign;
    next_phase_noload_state = phase_noload_state;
    next_tick_cnt = tick ? 5'(energy_cond_pkg::STAGE1_TICK_CYCLES - 1) : tick_cnt - 5'h01;
    next_acc = acc;
    next_last_sign = last_sign;
    next_sign_pending = sign_pending;
    next_stage1_pulse = 3'h0;
    set0 = 32'h0;
    set1 = 32'h0;
    clr0 = 32'h0;
    clr1 = 32'h0;

    // register writes; sign and no-load state are not writable
    if (reg_wr) begin
      unique case (reg_addr)
        energy_cond_pkg::ADDR_ACCUM_MODE: next_accumulation_mode = reg_wdata[7:0];
        energy_cond_pkg::ADDR_ACTIVE_STATUS: clr0 = reg_wdata;
        energy_cond_pkg::ADDR_ACTIVE_MASK: next_active_mask = reg_wdata;
        energy_cond_pkg::ADDR_ACTIVE_NL_THR: next_active_noload_threshold = reg_wdata[23:0];
        energy_cond_pkg::ADDR_REACTIVE_NL_THR: next_reactive_noload_threshold = reg_wdata[23:0];
        energy_cond_pkg::ADDR_SECONDARY_STATUS: clr1 = reg_wdata;
        energy_cond_pkg::ADDR_SECONDARY_MASK: next_secondary_mask = reg_wdata;
        energy_cond_pkg::ADDR_APPARENT_NL_THR: next_apparent_noload_threshold = reg_wdata[23:0];
        default: ;
      endcase
    end

    // no-load detectors, evaluated per new power sample
    if (power_valid) begin
      for (int p = 0; p < 3; p++) begin
        next_phase_noload_state[energy_cond_pkg::NOLOAD_PHASE_LSB + p] = pq_en
          && magnitude(p_act[p]) <= 28'(thr_a) && magnitude(p_rea[p]) <= 28'(thr_r);
        next_phase_noload_state[energy_cond_pkg::APPARENT_NOLOAD_PHASE_LSB + p] = app_en
          && magnitude(p_app[p]) <= 28'(thr_v);
      end
    end
    if (next_phase_noload_state[2:0] != nl_pq) begin
      set1[energy_cond_pkg::NOLOAD_FLAG_BIT] = 1'b1;
    end
    if (next_phase_noload_state[8:6] != nl_app) begin
      set1[energy_cond_pkg::APPARENT_NOLOAD_FLAG_BIT] = 1'b1;
    end

    // first pulse stage per converter
    for (int k = 0; k < 3; k++) begin
      sel = pulse_power_type_select[3*k +: 3];
      unique case (sel)
        energy_cond_pkg::SEL_ACTIVE: ethr = active_energy_threshold;
        energy_cond_pkg::SEL_APPARENT: ethr = apparent_energy_threshold;
        default: ethr = reactive_energy_threshold;
      endcase
      sum = 30'sh0;
      for (int p = 0; p < 3; p++) begin
        if (phase_term_select[3*k + p]) begin
          sum = sum + cond_power(sel, amode, rmode, p_act[p], p_rea[p], p_app[p], nl_pq[p], nl_app[p]);
        end
      end
      thr7 = {1'b0, ethr, 7'h00};
      accx = {acc[k][54], acc[k]} + (56'(sum) <<< energy_cond_pkg::POWER_SHIFT);
      if (tick) begin
        if (accx >= thr7) begin
          accx = accx - thr7;
          next_stage1_pulse[k] = 1'b1;
          next_last_sign[k] = 1'b0;
          next_sign_pending[k] = sign_pending[k] | last_sign[k];
        end else if (accx <= -thr7) begin
          accx = accx + thr7;
          next_stage1_pulse[k] = 1'b1;
          next_last_sign[k] = 1'b1;
          next_sign_pending[k] = sign_pending[k] | !last_sign[k];
        end
        next_acc[k] = accx[54:0];
      end
      // the flag waits for the falling pulse edge so it lines up with the pin
      if (sign_pending[k] && pulse_output_fall[k]) begin
        set0[energy_cond_pkg::REV_SUM_BIT[k]] = 1'b1;
        next_phase_sign[energy_cond_pkg::SUM_SIGN_BIT[k]] = last_sign[k];
        next_sign_pending[k] = next_stage1_pulse[k] && (next_last_sign[k] != last_sign[k]);
      end
    end

    // flags set regardless of masks; a set in the clearing cycle survives
    next_active_status = (active_status & ~clr0) | set0;
    next_secondary_status = (secondary_status & ~clr1) | set1;
    next_first_irq_n = ~|(next_active_status & next_active_mask);
    next_second_irq_n = ~|(next_secondary_status & next_secondary_mask);

    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        energy_cond_pkg::ADDR_ACCUM_MODE: next_reg_rdata = {24'h0, accumulation_mode};
        energy_cond_pkg::ADDR_ACTIVE_STATUS: next_reg_rdata = active_status;
        energy_cond_pkg::ADDR_PHASE_SIGN: next_reg_rdata = {16'h0, phase_sign};
        energy_cond_pkg::ADDR_ACTIVE_MASK: next_reg_rdata = active_mask;
        energy_cond_pkg::ADDR_ACTIVE_NL_THR: next_reg_rdata = {4'h0, thr_a};
        energy_cond_pkg::ADDR_REACTIVE_NL_THR: next_reg_rdata = {4'h0, thr_r};
        energy_cond_pkg::ADDR_SECONDARY_STATUS: next_reg_rdata = secondary_status;
        energy_cond_pkg::ADDR_PHASE_NOLOAD: next_reg_rdata = {16'h0, phase_noload_state};
        energy_cond_pkg::ADDR_SECONDARY_MASK: next_reg_rdata = secondary_mask;
        energy_cond_pkg::ADDR_APPARENT_NL_THR: next_reg_rdata = {4'h0, thr_v};
        default: next_reg_rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accumulation_mode <= energy_cond_pkg::ACCUM_MODE_RESET;
      active_status <= 32'h0;
      phase_sign <= 16'h0;
      active_mask <= energy_cond_pkg::MASK_RESET;
      active_noload_threshold <= energy_cond_pkg::NL_THR_RESET;
      reactive_noload_threshold <= energy_cond_pkg::NL_THR_RESET;
      apparent_noload_threshold <= energy_cond_pkg::NL_THR_RESET;
      secondary_status <= 32'h0;
      phase_noload_state <= 16'h0;
      secondary_mask <= energy_cond_pkg::MASK_RESET;
      reg_rdata <= 32'h0;
      first_interrupt_line_n <= 1'b1;
      second_interrupt_line_n <= 1'b1;
      tick_cnt <= 5'h00;
      acc <= '{3{55'sh0}};
      last_sign <= 3'h0;
      sign_pending <= 3'h0;
      stage1_pulse <= 3'h0;
    end else begin
      accumulation_mode <= next_accumulation_mode;
      active_status <= next_active_status;
      phase_sign <= next_phase_sign;
      active_mask <= next_active_mask;
      active_noload_threshold <= next_active_noload_threshold;
      reactive_noload_threshold <= next_reactive_noload_threshold;
      apparent_noload_threshold <= next_apparent_noload_threshold;
      secondary_status <= next_secondary_status;
      phase_noload_state <= next_phase_noload_state;
      secondary_mask <= next_secondary_mask;
      reg_rdata <= next_reg_rdata;
      first_interrupt_line_n <= next_first_irq_n;
      second_interrupt_line_n <= next_second_irq_n;
      tick_cnt <= next_tick_cnt;
      acc <= next_acc;
      last_sign <= next_last_sign;
      sign_pending <= next_sign_pending;
      stage1_pulse <= next_stage1_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  for (genvar k = 0; k < 3; k++) begin : g_conv
    sequence s_change_seen;
      sign_pending[k] && pulse_output_fall[k];
    endsequence
    a_rev_flag_set: assert property (s_change_seen |=> active_status[energy_cond_pkg::REV_SUM_BIT[k]])
      else $error("reverse-sum flag not set on falling pulse edge");
    a_rev_flag_cause: assert property ($rose(active_status[energy_cond_pkg::REV_SUM_BIT[k]])
      |-> $past(sign_pending[k] && pulse_output_fall[k]))
      else $error("reverse-sum flag set without pending change and falling edge");
    a_sum_sign_copy: assert property (s_change_seen ##1 1'b1
      |-> phase_sign[energy_cond_pkg::SUM_SIGN_BIT[k]] == $past(last_sign[k]))
      else $error("sum sign bit does not match detected sign");
  end

  a_first_interrupt_line_mask: assert property (first_interrupt_line_n == !(|(active_status & active_mask)))
    else $error("first interrupt line disagrees with masked status");
  a_second_interrupt_line_mask: assert property (second_interrupt_line_n == !(|(secondary_status & secondary_mask)))
    else $error("second interrupt line disagrees with masked status");
  a_w1c_clear: assert property (reg_wr && reg_addr == energy_cond_pkg::ADDR_SECONDARY_STATUS
    && reg_wdata[0] && !(power_valid) |=> !secondary_status[0])
    else $error("write-one did not clear no-load flag");
  a_nl_flag: assert property ($changed(phase_noload_state[2:0]) |-> secondary_status[0])
    else $error("power no-load change without status flag");
  a_app_flag: assert property ($changed(phase_noload_state[8:6]) |-> secondary_status[2])
    else $error("apparent no-load change without status flag");
  a_nl_disabled: assert property (power_valid && active_noload_threshold[23]
    |=> phase_noload_state[2:0] == 3'h0)
    else $error("power no-load detector active with negative threshold");
  a_ro_sign: assert property (reg_wr && reg_addr == energy_cond_pkg::ADDR_PHASE_SIGN
    && !(|(sign_pending & pulse_output_fall)) |=> $stable(phase_sign))
    else $error("phase sign register changed by a write");
  a_tick_period: assert property (tick |=> !tick [*8])
    else $error("first stage tick too frequent");
  a_pulse_tick: assert property (|stage1_pulse |-> $past(tick))
    else $error("first stage pulse outside a tick");

endmodule : energy_pulse_cond
`default_nettype wire

// [pkg/energy_cond_pkg.sv]
`default_nettype none
package energy_cond_pkg;
  // register index on the internal register port
  localparam logic [3:0] ADDR_ACCUM_MODE = 4'h0;
  localparam logic [3:0] ADDR_ACTIVE_STATUS = 4'h1;
  localparam logic [3:0] ADDR_PHASE_SIGN = 4'h2;
  localparam logic [3:0] ADDR_ACTIVE_MASK = 4'h3;
  localparam logic [3:0] ADDR_ACTIVE_NL_THR = 4'h4;
  localparam logic [3:0] ADDR_REACTIVE_NL_THR = 4'h5;
  localparam logic [3:0] ADDR_SECONDARY_STATUS = 4'h6;
  localparam logic [3:0] ADDR_PHASE_NOLOAD = 4'h7;
  localparam logic [3:0] ADDR_SECONDARY_MASK = 4'h8;
  localparam logic [3:0] ADDR_APPARENT_NL_THR = 4'h9;

  // field positions
  localparam int ACTIVE_ACC_LSB = 0;
  localparam int REACTIVE_ACC_LSB = 2;
  localparam int REV_SUM_BIT[3] = '{9, 13, 18};
  localparam int SUM_SIGN_BIT[3] = '{3, 7, 8};
  localparam int NOLOAD_FLAG_BIT = 0;
  localparam int APPARENT_NOLOAD_FLAG_BIT = 2;
  localparam int NOLOAD_PHASE_LSB = 0;
  localparam int APPARENT_NOLOAD_PHASE_LSB = 6;

  // accumulation mode codes
  localparam logic [1:0] ACC_SIGNED = 2'h0;
  localparam logic [1:0] ACC_ABSOLUTE = 2'h3;
  localparam logic [1:0] ACC_SIGN_ADJUSTED = 2'h2;

  // power type routed to a converter
  localparam logic [2:0] SEL_ACTIVE = 3'h0;
  localparam logic [2:0] SEL_REACTIVE = 3'h1;
  localparam logic [2:0] SEL_APPARENT = 3'h2;
  localparam logic [2:0] SEL_REACTIVE_FUND = 3'h4;

  // reset values
  localparam logic [7:0] ACCUM_MODE_RESET = 8'h00;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [23:0] NL_THR_RESET = 24'h00_0000;

  // widths and timing
  localparam int POWER_W = 28;
  localparam int ACC_W = 55;
  localparam int ETHR_W = 48;
  localparam int POWER_SHIFT = 7;
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int STAGE1_RATE_HZ = 1_000_000;
  localparam int STAGE1_TICK_CYCLES = CLK_FREQ_HZ / STAGE1_RATE_HZ;
endpackage : energy_cond_pkg
`default_nettype wire

// [tb/host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // stale write data is scrambled so a late sample cannot pass by luck
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  // status, then the sign word, then the same status written back
  task automatic service(output logic [31:0] st, output logic [31:0] sg);
    rd(energy_cond_pkg::ADDR_ACTIVE_STATUS, st);
    rd(energy_cond_pkg::ADDR_PHASE_SIGN, sg);
    wr(energy_cond_pkg::ADDR_ACTIVE_STATUS, st);
  endtask : service
endmodule : host_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [3:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  row_t rows[5];
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_valid = 1'b0;
  logic [2:0] fall_q = 3'h0;
  logic signed [27:0] act[3] = '{28'sh3e8, 28'sh0, 28'sh0};
  logic signed [27:0] rea[3] = '{28'sh3e8, 28'sh0, 28'sh0};
  logic signed [27:0] app[3] = '{28'sh3e8, 28'sh0, 28'sh0};
  logic [3:0] reg_addr;
  logic reg_wr, reg_rd;
  logic [31:0] reg_wdata, reg_rdata, st, sg, v;
  logic [2:0] stage1_pulse, pnl, anl;
  logic line1_n, line2_n;
  logic seen_third = 1'b0;
  logic [2:0] sel3 = 3'h3;
  int n;
  int n_errors = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  always @(posedge clk) if (stage1_pulse[2] === 1'b1) seen_third <= 1'b1;
  // converter 3 starts on a reserved type code; every converter sums phase a only
  energy_pulse_cond energy_pulse_cond_i (.clk(clk), .rst_n(rst_n), .power_valid(power_valid),
    .active_power_a(act[0]), .active_power_b(act[1]), .active_power_c(act[2]),
    .reactive_power_a(rea[0]), .reactive_power_b(rea[1]), .reactive_power_c(rea[2]),
    .apparent_power_a(app[0]), .apparent_power_b(app[1]), .apparent_power_c(app[2]),
    .pulse_power_type_select({sel3, 6'h08}), .phase_term_select(9'h049),
    .active_energy_threshold(48'h3e8), .reactive_energy_threshold(48'h3e8),
    .apparent_energy_threshold(48'h3e8), .pulse_output_fall(fall_q),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .stage1_pulse(stage1_pulse), .power_noload_phase_state(pnl),
    .apparent_noload_phase_state(anl), .first_interrupt_line_n(line1_n),
    .second_interrupt_line_n(line2_n));
  host_model host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic wait_pulse(input int k, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (stage1_pulse[k] !== 1'b1 && c < 60);
    if (c >= 60) begin
      chk("pulse wait", 32'h1, 32'h0);
      summarize();
    end
  endtask : wait_pulse
  task automatic pulse_both;
    wait_pulse(1, n);
    wait_pulse(1, n);
    @(negedge clk);
    fall_q = 3'h7;
    @(negedge clk);
    fall_q = 3'h0;
  endtask : pulse_both
  // lines are registered, so two falling edges let any update land
  task automatic lines(input logic [1:0] e);
    repeat (2) @(negedge clk);
    chk("lines", {30'h0, e}, {30'h0, line2_n, line1_n});
  endtask : lines
  task automatic sample;
    @(negedge clk);
    power_valid = 1'b1;
    @(negedge clk);
    power_valid = 1'b0;
    @(negedge clk);
  endtask : sample
  initial begin
    rows = '{'{energy_cond_pkg::ADDR_ACTIVE_MASK, 32'h0004_2200, 32'h0004_2200},
      '{energy_cond_pkg::ADDR_SECONDARY_MASK, 32'h0000_0005, 32'h0000_0005},
      '{energy_cond_pkg::ADDR_REACTIVE_NL_THR, 32'hfff8_0000, 32'h0ff8_0000},
      '{energy_cond_pkg::ADDR_APPARENT_NL_THR, 32'h0001_2345, 32'h0001_2345},
      '{energy_cond_pkg::ADDR_PHASE_SIGN, 32'hffff_ffff, 32'h0}};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    lines(2'b11);
    for (int a = 0; a < 16; a++) begin
      host_model_i.rd(4'(a), v);
      chk("reset value", 32'h0, v);
    end
    foreach (rows[i]) begin
      host_model_i.wr(rows[i].a, rows[i].d);
      host_model_i.rd(rows[i].a, v);
      chk("register", rows[i].e, v);
    end
    wait_pulse(0, n);
    wait_pulse(0, n);
    chk("tick spacing", 32'h19, 32'(n));
    // a reserved type code must never have pulsed
    chk("third converter", 32'h0, {31'h0, seen_third});
    sel3 = energy_cond_pkg::SEL_APPARENT;
    wait_pulse(2, n);
    wait_pulse(2, n);
    chk("apparent spacing", 32'h19, 32'(n));
    pulse_both();
    lines(2'b11);
    // mode lands before the powers flip, so no tick sees a half-made setup
    sel3 = energy_cond_pkg::SEL_REACTIVE_FUND;
    host_model_i.wr(energy_cond_pkg::ADDR_ACCUM_MODE, 32'h08);
    act[0] = -28'sh3e8;
    rea[0] = -28'sh3e8;
    pulse_both();
    lines(2'b10);
    host_model_i.service(st, sg);
    chk("reverse sums", 32'h0000_0200, st);
    chk("sum signs", 32'h8, sg);
    lines(2'b11);
    host_model_i.wr(energy_cond_pkg::ADDR_ACCUM_MODE, 32'h03);
    pulse_both();
    host_model_i.service(st, sg);
    chk("reverse sums", 32'h0004_2200, st);
    chk("sum signs", 32'h180, sg);
    lines(2'b11);
    host_model_i.wr(energy_cond_pkg::ADDR_ACTIVE_NL_THR, 32'h64);
    host_model_i.wr(energy_cond_pkg::ADDR_REACTIVE_NL_THR, 32'h64);
    host_model_i.wr(energy_cond_pkg::ADDR_APPARENT_NL_THR, 32'h28);
    act = '{28'sh32, 28'shc8, 28'sh0};
    rea = '{-28'sh32, 28'sh0, -28'shc8};
    app = '{-28'sh1e, 28'sh3e8, 28'sh3e8};
    sample();
    chk("power noload", 32'h1, {29'h0, pnl});
    chk("apparent noload", 32'h1, {29'h0, anl});
    lines(2'b01);
    host_model_i.wr(energy_cond_pkg::ADDR_PHASE_NOLOAD, 32'h0);
    host_model_i.rd(energy_cond_pkg::ADDR_PHASE_NOLOAD, v);
    chk("noload state", 32'h41, v);
    host_model_i.wr(energy_cond_pkg::ADDR_SECONDARY_STATUS, 32'h1);
    lines(2'b01);
    host_model_i.rd(energy_cond_pkg::ADDR_SECONDARY_STATUS, v);
    chk("secondary status", 32'h4, v);
    host_model_i.wr(energy_cond_pkg::ADDR_SECONDARY_STATUS, 32'h4);
    lines(2'b11);
    host_model_i.wr(energy_cond_pkg::ADDR_ACTIVE_NL_THR, 32'h00ff_ffff);
    host_model_i.wr(energy_cond_pkg::ADDR_APPARENT_NL_THR, 32'h00ff_ffff);
    host_model_i.wr(energy_cond_pkg::ADDR_SECONDARY_MASK, 32'h0);
    sample();
    chk("power noload", 32'h0, {29'h0, pnl});
    chk("apparent noload", 32'h0, {29'h0, anl});
    lines(2'b11);
    host_model_i.rd(energy_cond_pkg::ADDR_SECONDARY_STATUS, v);
    chk("secondary status", 32'h5, v);
    // a mid-run reset must return flags and masks to zero
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    host_model_i.rd(energy_cond_pkg::ADDR_SECONDARY_STATUS, v);
    chk("reset status", 32'h0, v);
    host_model_i.rd(energy_cond_pkg::ADDR_ACTIVE_MASK, v);
    chk("reset mask", 32'h0, v);
    summarize();
  end
endmodule : testbench
`default_nettype wire
